// File: fhb_map.svh
/*
 fhb_map.svh: offsets, block boundaries and timing figures of the flash host
 bus interface. Assumes inclusion by bare name from the package and modules.
*/
`ifndef FHB_MAP_SVH
`define FHB_MAP_SVH

// word address width and data width
`define FHB_AW            20
`define FHB_DW            32
`define FHB_SW            8
// block boundaries, 32-bit word units
`define FHB_SMALL_BASE    20'h0_4000
`define FHB_MAIN_BASE     20'h0_8000
`define FHB_NOTP_LO       20'h0_8000
`define FHB_NOTP_HI       20'h0_FFFF
// block index fields and bases
`define FHB_MAIN_LSB      14
`define FHB_SMALL_LSB     11
`define FHB_LARGE_LSB     12
`define FHB_MAIN_IDX0     7'h0A
`define FHB_SMALL_IDX0    7'h04
`define FHB_OTP_IDX       7'h01
// reference clock and reset release delays (figures not fixed, plain defaults)
`define FHB_CLK_MHZ       40
`define FHB_T_RD_NS       150
`define FHB_T_WR_NS       150
// burst initial latency in burst clock cycles
`define FHB_X_LAT         4

`endif

// File: fhb_pkg.sv
/*
 fhb_pkg: types shared by the flash host bus interface modules.
 Assumes fhb_map.svh is on the include path.
*/
`include "fhb_map.svh"
package fhb_pkg;
   typedef logic [`FHB_AW-1:0] fhb_addr_t;
   typedef logic [`FHB_DW-1:0] fhb_data_t;
   typedef logic [6:0]         fhb_blk_t;
   // write strobe cycle, gray from idle through low to done
   typedef enum logic [1:0] {
      FHB_W_IDLE = 2'b00,
      FHB_W_LOW  = 2'b01,
      FHB_W_DONE = 2'b11
   } fhb_wst_e;
endpackage

// File: fhb_if.sv
/*
 fhb_if: carrier between the core (reference clock) and the burst front end
 (burst clock). Assumes a toggle handshake: addr stays still while req != ack.
*/
`timescale 1ns/1ps
interface fhb_if;
   import fhb_pkg::*;
   logic      sync_mode;
   fhb_addr_t addr;
   logic      req;
   logic      ack;
   modport burst (input sync_mode, input ack, output addr, output req);
   modport core  (output sync_mode, output ack, input addr, input req);
endinterface

// File: fhb_sync.sv
/*
 fhb_sync: two flip-flop level synchroniser, one per bit.
 Assumes async active low reset and a destination clock.
*/
`timescale 1ns/1ps
module fhb_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   if (W < 1) begin : g_bad_w
      $error("fhb_sync width must be at least one");
   end
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // fhb_sync

// File: fhb_burst.sv
/*
 fhb_burst: burst clock front end. Captures the burst start address and
 advances the burst counter; hands each address to the core by toggle.
 Assumes burst pins are timed to the burst clock, which may stop between reads.
*/
`timescale 1ns/1ps
`include "fhb_map.svh"
module fhb_burst #(
   parameter int X_LAT = `FHB_X_LAT
) (
   input  wire logic              burst_clk,
   input  wire logic              rstn,
   input  wire logic              chip_sel_n,
   input  wire logic              latch_en_n,
   input  wire logic              burst_adv_n,
   input  wire fhb_pkg::fhb_addr_t word_address,
   fhb_if.burst                   lnk
);
   import fhb_pkg::*;
   logic       mode_s;
   logic       ack_s;
   logic       cap_r, cap_nxt;
   logic [3:0] lat_r, lat_nxt;
   fhb_addr_t  cnt_r, cnt_nxt;
   logic       req_r, req_nxt;
   if (X_LAT < 1 || X_LAT > 15) begin : g_bad_lat
      $error("fhb_burst latency out of range");
   end
   fhb_sync #(.W(2)) u_sync (
      .clk  (burst_clk),
      .rstn (rstn),
      .d    ({lnk.sync_mode, lnk.ack}),
      .q    ({mode_s, ack_s})
   );
   // clock ignored unless the burst configuration has been written
   always_comb begin
      cap_nxt = cap_r;
      lat_nxt = lat_r;
      cnt_nxt = cnt_r;
      req_nxt = req_r;
      if (!mode_s || chip_sel_n) begin
         cap_nxt = 1'b0;
      end else if (!latch_en_n && !cap_r) begin
         cnt_nxt = word_address;
         cap_nxt = 1'b1;
         lat_nxt = 4'(X_LAT);
         req_nxt = ~req_r;
      end else if (latch_en_n && cap_r) begin
         if (lat_r != 4'h0) begin
            lat_nxt = lat_r - 4'h1;
         end else if (!burst_adv_n && req_r == ack_s) begin
            cnt_nxt = cnt_r + 20'h0_0001;
            req_nxt = ~req_r;
         end
      end
      if (latch_en_n && !cap_r) begin
         cap_nxt = 1'b0;
      end
   end
   always_ff @(posedge burst_clk or negedge rstn) begin
      if (!rstn) begin
         cap_r <= 1'b0;
         lat_r <= 4'h0;
         cnt_r <= '0;
         req_r <= 1'b0;
      end else begin
         cap_r <= cap_nxt;
         lat_r <= lat_nxt;
         cnt_r <= cnt_nxt;
         req_r <= req_nxt;
      end
   end
   assign lnk.addr = cnt_r;
   assign lnk.req  = req_r;
endmodule // fhb_burst

// File: fhb_top.sv
/*
 fhb_top: host bus interface of a 32-bit parallel flash. Latches address and
 data, drives or floats the data bus, decodes blocks, handles reset/power-down
 and program/erase enable, and takes burst start addresses from the burst
 clock front end. Assumes the array and command logic sit on the user ports,
 and that pins are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "fhb_map.svh"
// What this block does
// - decode word addresses into blocks of 512, 64, 128 Kbit; block 1 is OTP
// - blocks at 08000h-0FFFFh are never tuning protectable; others are
// - twenty-bit word address selects cells or command targets
// - read address taken at first of latch rise or burst clock rise
// - write address taken at first rise of chip select, write strobe or latch
// - latch transparent while latch strobe low; address held during program/erase
// - write data taken at first rise of write strobe or chip select
// - drive data bus when selected, output enable low and disable high
// - float bus if deselected, output enable high, disable low or in reset
// - status byte on low eight lines, upper lines driven low
// - chip select high deselects, blocks inputs, signals standby
// - output enable high floats outputs regardless of output disable
// - output disable low floats outputs; high leaves output enable in control
// - reset low inhibits writes, resets controller, clears status, floats bus
// - reads and writes wait their own delays after reset release
// - reset during program or erase aborts it promptly
// - program/erase enable low blocks all program and erase
// - burst address taken on first clock rise with latch low; a latch rise without such a clock rise takes none
// - burst clock only serves synchronous burst reads
// - burst clock ignored in asynchronous operation
// - asynchronous after reset until burst configuration is written
// - after latency, burst counter advances when advance low, else holds
module fhb_top #(
   parameter int T_RD_NS = `FHB_T_RD_NS,
   parameter int T_WR_NS = `FHB_T_WR_NS,
   parameter int X_LAT   = `FHB_X_LAT
) (
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   input  wire logic               burst_clk,
   input  wire logic               chip_sel_n,
   input  wire logic               out_en_n,
   input  wire logic               output_disable_n,
   input  wire logic               write_en_n,
   input  wire logic               latch_en_n,
   input  wire logic               burst_adv_n,
   input  wire logic               reset_powerdown_n,
   input  wire logic               program_erase_enable,
   input  wire fhb_pkg::fhb_addr_t word_address,
   input  wire fhb_pkg::fhb_data_t data_bus_i,
   output fhb_pkg::fhb_data_t      data_bus_o,
   output logic                    data_bus_oe,
   output fhb_pkg::fhb_addr_t      arr_addr,
   input  wire fhb_pkg::fhb_data_t arr_rd_data,
   input  wire logic               rd_sel_status,
   input  wire logic [7:0]         status_byte,
   output logic                    wr_valid,
   output fhb_pkg::fhb_addr_t      wr_addr,
   output fhb_pkg::fhb_data_t      wr_data,
   input  wire logic               burst_cfg_set,
   input  wire logic               pe_active,
   output logic                    pe_permit,
   output logic                    pe_abort,
   output logic                    ctl_reset,
   output logic                    standby,
   output fhb_pkg::fhb_blk_t       blk_index,
   output logic                    blk_otp,
   output logic                    blk_tuning_protectable,
   output logic                    read_ready,
   output logic                    write_ready,
   output logic                    sync_mode
);
   import fhb_pkg::*;

   // release delays, rounded up to whole cycles, at least one
   localparam int RD_RAW = (T_RD_NS * `FHB_CLK_MHZ + 999) / 1000;
   localparam int WR_RAW = (T_WR_NS * `FHB_CLK_MHZ + 999) / 1000;
   localparam int RD_CYC = (RD_RAW < 1) ? 1 : RD_RAW;
   localparam int WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
   localparam int CW     = 12;

   if (RD_CYC >= (1 << CW) || WR_CYC >= (1 << CW)) begin : g_bad_dly
      $error("fhb_top release delay too long for counter");
   end
   if (X_LAT < 1 || X_LAT > 15) begin : g_bad_lat
      $error("fhb_top burst latency out of range");
   end

   fhb_if lnk ();

   // pins through two flip-flops before any ref_clk logic; the burst front end takes its pins direct
   logic      cs_n_s, oe_n_s, od_n_s, we_n_s, le_n_s, rp_n_s, pee_s;
   fhb_addr_t addr_s;
   fhb_data_t din_s;
   logic      breq_s;
   fhb_sync #(.W(8)) u_sync_ctl (
      .clk  (ref_clk),
      .rstn (rstn),
      .d    ({chip_sel_n, out_en_n, output_disable_n, write_en_n,
              latch_en_n, reset_powerdown_n, program_erase_enable, lnk.req}),
      .q    ({cs_n_s, oe_n_s, od_n_s, we_n_s, le_n_s, rp_n_s, pee_s, breq_s})
   );
   fhb_sync #(.W(`FHB_AW + `FHB_DW)) u_sync_bus (
      .clk  (ref_clk),
      .rstn (rstn),
      .d    ({word_address, data_bus_i}),
      .q    ({addr_s, din_s})
   );

   fhb_burst #(.X_LAT(X_LAT)) u_burst (
      .burst_clk    (burst_clk),
      .rstn         (rstn),
      .chip_sel_n   (chip_sel_n),
      .latch_en_n   (latch_en_n),
      .burst_adv_n  (burst_adv_n),
      .word_address (word_address),
      .lnk          (lnk)
   );

   // previous samples for edge detection
   logic le_n_q, rp_n_q;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         le_n_q <= 1'b1;
         rp_n_q <= 1'b0;
      end else begin
         le_n_q <= le_n_s;
         rp_n_q <= rp_n_s;
      end
   end
   logic le_rise, rp_fall, in_reset;
   assign le_rise  = le_n_s && !le_n_q;
   assign rp_fall  = !rp_n_s && rp_n_q;
   assign in_reset = !rp_n_s;

   // reset release counters and burst mode flag
   logic [CW-1:0] rd_cnt_r, rd_cnt_nxt, wr_cnt_r, wr_cnt_nxt;
   logic          mode_r, mode_nxt, ack_r, ack_nxt;
   always_comb begin
      rd_cnt_nxt = rd_cnt_r;
      wr_cnt_nxt = wr_cnt_r;
      mode_nxt   = mode_r;
      if (in_reset) begin
         rd_cnt_nxt = CW'(RD_CYC);
         wr_cnt_nxt = CW'(WR_CYC);
         mode_nxt   = 1'b0;
      end else begin
         if (rd_cnt_r != '0) rd_cnt_nxt = rd_cnt_r - CW'(1);
         if (wr_cnt_r != '0) wr_cnt_nxt = wr_cnt_r - CW'(1);
         if (burst_cfg_set) mode_nxt = 1'b1;
      end
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_cnt_r <= CW'(RD_CYC);
         wr_cnt_r <= CW'(WR_CYC);
         mode_r   <= 1'b0;
      end else begin
         rd_cnt_r <= rd_cnt_nxt;
         wr_cnt_r <= wr_cnt_nxt;
         mode_r   <= mode_nxt;
      end
   end
   assign read_ready    = rp_n_s && (rd_cnt_r == '0);
   assign write_ready   = rp_n_s && (wr_cnt_r == '0);
   assign sync_mode     = mode_r;
   assign lnk.sync_mode = mode_r;
   assign lnk.ack       = ack_r;

   // write strobe sequence: address taken at first rise of latch, strobe or chip select, data at first rise of strobe or chip select
   fhb_wst_e  wst_r, wst_nxt;
   fhb_addr_t wadr_r, wadr_nxt;
   fhb_data_t wdat_r, wdat_nxt;
   logic      wv_r, wv_nxt, wadr_held_r, wadr_held_nxt;
   logic      pe_busy;
   assign pe_busy = pe_active;
   always_comb begin
      wst_nxt       = wst_r;
      wadr_nxt      = wadr_r;
      wdat_nxt      = wdat_r;
      wv_nxt        = 1'b0;
      wadr_held_nxt = wadr_held_r;
      if (le_n_s) wadr_held_nxt = wadr_held_r;
      else wadr_held_nxt = 1'b0;
      if (le_rise && !cs_n_s && !we_n_s && wst_r == FHB_W_LOW) begin
         wadr_nxt      = addr_s;
         wadr_held_nxt = 1'b1;
      end
      case (wst_r)
         FHB_W_IDLE: begin
            if (!cs_n_s && !we_n_s && write_ready && !pe_busy) begin
               wst_nxt = FHB_W_LOW;
            end
         end
         FHB_W_LOW: begin
            if (in_reset) begin
               wst_nxt = FHB_W_IDLE;
            end else if (cs_n_s || we_n_s) begin
               if (!wadr_held_r) wadr_nxt = addr_s;
               wdat_nxt = din_s;
               wv_nxt   = 1'b1;
               wst_nxt  = FHB_W_DONE;
            end
         end
         FHB_W_DONE: begin
            if (cs_n_s && we_n_s) wst_nxt = FHB_W_IDLE;
         end
         default: wst_nxt = FHB_W_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wst_r       <= FHB_W_IDLE;
         wadr_r      <= '0;
         wdat_r      <= '0;
         wv_r        <= 1'b0;
         wadr_held_r <= 1'b0;
      end else begin
         wst_r       <= wst_nxt;
         wadr_r      <= wadr_nxt;
         wdat_r      <= wdat_nxt;
         wv_r        <= wv_nxt;
         wadr_held_r <= wadr_held_nxt;
      end
   end
   assign wr_valid = wv_r;
   assign wr_addr  = wadr_r;
   assign wr_data  = wdat_r;

   // read address latch: transparent while latch low, frozen on first capture
   fhb_addr_t radr_r, radr_nxt;
   logic      bcap_r, bcap_nxt;
   always_comb begin
      radr_nxt = radr_r;
      bcap_nxt = bcap_r;
      ack_nxt  = ack_r;
      if (breq_s != ack_r) begin
         ack_nxt = breq_s;                                  // word stable until ack
         if (mode_r && !pe_busy) begin
            radr_nxt = lnk.addr;
            bcap_nxt = 1'b1;
         end
      end else if (pe_busy || cs_n_s) begin
         radr_nxt = radr_r;
      end else if (!le_n_s && !bcap_r) begin
         radr_nxt = addr_s;
      end
      if (le_rise) bcap_nxt = 1'b0;                         // latch rise closes the cycle
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         radr_r <= '0;
         bcap_r <= 1'b0;
         ack_r  <= 1'b0;
      end else begin
         radr_r <= radr_nxt;
         bcap_r <= bcap_nxt;
         ack_r  <= ack_nxt;
      end
   end
   assign arr_addr = pe_busy ? wadr_r : radr_r;

   // block decode of the array address, bottom boot layout
   always_comb begin
      if (arr_addr >= `FHB_MAIN_BASE) begin
         blk_index = `FHB_MAIN_IDX0 + 7'(arr_addr[`FHB_AW-1:`FHB_MAIN_LSB]);
      end else if (arr_addr >= `FHB_SMALL_BASE) begin
         blk_index = `FHB_SMALL_IDX0 + 7'(arr_addr[`FHB_MAIN_LSB-1:`FHB_SMALL_LSB]);
      end else begin
         blk_index = 7'(arr_addr[`FHB_MAIN_LSB-1:`FHB_LARGE_LSB]);
      end
   end
   assign blk_otp = (blk_index == `FHB_OTP_IDX);
   assign blk_tuning_protectable = !(arr_addr >= `FHB_NOTP_LO &&
                                     arr_addr <= `FHB_NOTP_HI);

   // output data register; status zero-extends on the upper lines
   fhb_data_t dout_r, dout_nxt;
   always_comb begin
      if (in_reset) begin
         dout_nxt = '0;
      end else if (rd_sel_status) begin
         dout_nxt = {{(`FHB_DW - `FHB_SW){1'b0}}, status_byte};
      end else begin
         dout_nxt = arr_rd_data;
      end
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) dout_r <= '0;
      else dout_r <= dout_nxt;
   end
   assign data_bus_o = dout_r;
   // drive only when every enable agrees; any one floats the bus
   assign data_bus_oe = !cs_n_s && !oe_n_s && od_n_s && rp_n_s && read_ready;

   // power state and program/erase guard
   assign standby   = cs_n_s || in_reset;
   assign ctl_reset = in_reset;
   assign pe_permit = pee_s && rp_n_s;
   assign pe_abort  = pe_active && (rp_fall || in_reset);

endmodule // fhb_top

// File: fhb_host.sv
/*
 fhb_host: host model on the pins of fhb_top, with tasks for pin levels,
 writes and the reset pin. Assumes calls from tb between clock edges.
*/
`timescale 1ns/1ps
module fhb_host (
   input  wire logic               clk,
   input  wire fhb_pkg::fhb_data_t data_bus_o,
   input  wire logic               data_bus_oe,
   output logic                    chip_sel_n,
   output logic                    out_en_n,
   output logic                    output_disable_n,
   output logic                    write_en_n,
   output logic                    latch_en_n,
   output logic                    reset_powerdown_n,
   output fhb_pkg::fhb_addr_t      word_address,
   output fhb_pkg::fhb_data_t      data_bus_i
);
   import fhb_pkg::*;
   fhb_data_t dq;
   logic      drv;
   // wire level; a released bus shows a stale inverse, not the old word
   assign data_bus_i = data_bus_oe ? data_bus_o : (drv ? dq : ~dq);
   // power-up: chip select, output and write enables high, latch low, reset pin low
   initial begin
      {chip_sel_n, out_en_n, write_en_n} = 3'b111;
      {output_disable_n, latch_en_n, drv} = 3'b100;
      reset_powerdown_n = 1'b0;
      word_address = '0;
      dq = '0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // {cs, oe, od} pin levels plus latch and address
   task automatic set(input logic [2:0] c, input logic le, input fhb_addr_t a);
      tick(1);
      {chip_sel_n, out_en_n, output_disable_n} = c;
      latch_en_n = le;
      word_address = a;
   endtask
   // one word; each level held four cycles so the synchronisers see it
   task automatic wr(input fhb_addr_t a, input fhb_data_t d, input logic lc = 1'b0);
      tick(1);
      {out_en_n, latch_en_n, word_address, dq, drv} = {2'b10, a, d, 1'b1};
      chip_sel_n = 1'b0;
      write_en_n = 1'b0;
      tick(4);
      // optional latch rise mid-write; address pins then move on
      if (lc) begin
         latch_en_n = 1'b1;
         tick(4);
         word_address = ~a;
         tick(4);
      end
      write_en_n = 1'b1;
      tick(4);
      chip_sel_n = 1'b1;
      drv = 1'b0;
      word_address = ~a;
      tick(4);
   endtask
   task automatic rp(input logic v, input int n);
      tick(1);
      reset_powerdown_n = v;
      tick(n);
   endtask
endmodule // fhb_host

// File: fhb_top_sva.sv
/*
 fhb_top_sva: port checker for fhb_top on ref_clk.
 Assumes pins reach the core through two flip-flops.
*/
`timescale 1ns/1ps
module fhb_top_sva (
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   input  wire logic               chip_sel_n,
   input  wire logic               out_en_n,
   input  wire logic               output_disable_n,
   input  wire logic               write_en_n,
   input  wire logic               reset_powerdown_n,
   input  wire logic               program_erase_enable,
   input  wire logic               pe_active,
   input  wire logic               rd_sel_status,
   input  wire logic [7:0]         status_byte,
   input  wire logic               burst_cfg_set,
   input  wire fhb_pkg::fhb_data_t data_bus_o,
   input  wire logic               data_bus_oe,
   input  wire logic               wr_valid,
   input  wire logic               pe_permit,
   input  wire logic               pe_abort,
   input  wire logic               ctl_reset,
   input  wire logic               standby,
   input  wire logic               read_ready,
   input  wire logic               sync_mode,
   input  wire fhb_pkg::fhb_addr_t arr_addr,
   input  wire logic               blk_otp,
   input  wire logic               blk_tuning_protectable
);
   import fhb_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // four samples cover the two sync flops plus a register
   a_float_desel: assert property (chip_sel_n[*4] |-> !data_bus_oe && standby)
      else $error("bus driven or awake while deselected");
   a_float_oe: assert property (out_en_n[*4] |-> !data_bus_oe)
      else $error("bus driven with output enable high");
   a_float_odis: assert property (!output_disable_n[*4] |-> !data_bus_oe)
      else $error("bus driven with output disable low");
   a_drive_read: assert property ((!chip_sel_n && !out_en_n && output_disable_n && write_en_n
      && read_ready)[*4] |-> data_bus_oe)
      else $error("bus not driven on a read");
   a_status_word: assert property (data_bus_oe && $past(data_bus_oe) && $past(rd_sel_status)
      |-> data_bus_o == {24'h00_0000, $past(status_byte)})
      else $error("status word malformed");
   a_wr_pulse: assert property (wr_valid |-> ($past(write_en_n, 2) || $past(chip_sel_n, 2))
      ##1 !wr_valid)
      else $error("write pulse without strobe rise or too long");
   a_wr_refused: assert property ((pe_active || !reset_powerdown_n)[*4] |-> !wr_valid)
      else $error("write accepted while refused");
   a_pe_block: assert property (!program_erase_enable[*4] |-> !pe_permit)
      else $error("program allowed with enable low");
   a_abort_reset: assert property ((pe_active && !reset_powerdown_n)[*4]
      |-> pe_abort && ctl_reset && !sync_mode && !data_bus_oe)
      else $error("reset pin did not abort and reset");
   a_sync_cause: assert property ($rose(sync_mode)
      |-> $past(burst_cfg_set) || $past(burst_cfg_set, 2))
      else $error("burst mode without configuration");
   a_tp_map: assert property (blk_tuning_protectable
      == !(arr_addr >= 20'h0_8000 && arr_addr <= 20'h0_FFFF))
      else $error("tuning protection decode wrong");
   a_otp_map: assert property (blk_otp == (arr_addr[19:12] == 8'h01))
      else $error("otp decode wrong");
   c_write: cover property (wr_valid);
   c_status: cover property (data_bus_oe && rd_sel_status);
   c_abort: cover property (pe_abort);
   c_burst: cover property (sync_mode && !chip_sel_n);
endmodule // fhb_top_sva
bind fhb_top fhb_top_sva chk_i (.ref_clk, .rstn, .chip_sel_n, .out_en_n, .output_disable_n,
   .write_en_n, .reset_powerdown_n, .program_erase_enable, .pe_active, .rd_sel_status,
   .status_byte, .burst_cfg_set, .data_bus_o, .data_bus_oe, .wr_valid, .pe_permit, .pe_abort,
   .ctl_reset, .standby, .read_ready, .sync_mode, .arr_addr, .blk_otp, .blk_tuning_protectable);

// File: tb.sv
/*
 tb: self-checking bench for fhb_top with the fhb_host pin model.
 Assumes short release delays; burst clock only runs when bk_run is set.
*/
`timescale 1ns/1ps
module tb;
   import fhb_pkg::*;
   logic       ref_clk, rstn, burst_clk, bk_run, burst_adv_n, program_erase_enable;
   logic       pe_active, rd_sel_status, burst_cfg_set, chip_sel_n, out_en_n;
   logic       output_disable_n, write_en_n, latch_en_n, reset_powerdown_n, data_bus_oe;
   logic       wr_valid, pe_permit, pe_abort, ctl_reset, standby, blk_otp;
   logic       blk_tuning_protectable, read_ready, write_ready, sync_mode;
   logic [7:0] status_byte;
   fhb_addr_t  word_address, arr_addr, wr_addr, a;
   fhb_data_t  data_bus_i, data_bus_o, arr_rd_data, wr_data, d;
   fhb_blk_t   blk_index;
   logic [8:0] dec;
   logic [51:0] exp_q[$];
   int         mismatches, tests_run, cyc;
   fhb_addr_t  av[8] = '{20'h0_0FFF, 20'h0_1000, 20'h0_47FF, 20'h0_7800,
                         20'h0_8000, 20'h0_FFFF, 20'h1_0000, 20'hF_FFFF};
   fhb_top #(.T_RD_NS(25), .T_WR_NS(25), .X_LAT(2)) dut (.ref_clk, .rstn, .burst_clk,
      .chip_sel_n, .out_en_n, .output_disable_n, .write_en_n, .latch_en_n, .burst_adv_n,
      .reset_powerdown_n, .program_erase_enable, .word_address, .data_bus_i, .data_bus_o,
      .data_bus_oe, .arr_addr, .arr_rd_data, .rd_sel_status, .status_byte, .wr_valid,
      .wr_addr, .wr_data, .burst_cfg_set, .pe_active, .pe_permit, .pe_abort, .ctl_reset,
      .standby, .blk_index, .blk_otp, .blk_tuning_protectable, .read_ready, .write_ready,
      .sync_mode);
   fhb_host host (.clk(ref_clk), .data_bus_o, .data_bus_oe, .chip_sel_n, .out_en_n,
      .output_disable_n, .write_en_n, .latch_en_n, .reset_powerdown_n, .word_address,
      .data_bus_i);
   // 40 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // 6 ns burst clock, odd phase, gated by bk_run so it stands still while bk_run is clear
   initial begin
      burst_clk = 1'b0;
      #1.7;
      forever #3 burst_clk = bk_run & ~burst_clk;
   end
   task automatic chk(input logic [51:0] got, input logic [51:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 100 && write_ready !== 1'b1; i++) step(1);
      chk(write_ready & read_ready, 1'b1);
   endtask
   function automatic fhb_blk_t idx(input fhb_addr_t x);
      if (x < 20'h0_4000) return fhb_blk_t'(x >> 12);
      if (x < 20'h0_8000) return fhb_blk_t'(4 + ((x - 20'h0_4000) >> 11));
      return fhb_blk_t'(10 + (x >> 14));
   endfunction
   // every write pulse takes the oldest note; an unexpected pulse is a refusal missed
   always @(posedge ref_clk) begin
      if (wr_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(1'b1, 1'b0);
         else chk({wr_addr, wr_data}, exp_q.pop_front());
      end
   end
   // hang guard, well above the run length
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      {rstn, bk_run, burst_adv_n, program_erase_enable, pe_active} = 5'b00110;
      {rd_sel_status, burst_cfg_set, status_byte, arr_rd_data} = '0;
      void'($urandom(32'h0000_250b));
      step(12);
      rstn = 1'b1;
      host.rp(1'b1, 2);
      wait_ready();
      chk(sync_mode, 1'b0);
      // back-to-back random words, then one refused while busy
      repeat (4) begin
         a = fhb_addr_t'($urandom);
         d = $urandom;
         exp_q.push_back({a, d});
         host.wr(a, d);
      end
      pe_active = 1'b1;
      host.wr(a, ~d);
      pe_active = 1'b0;
      chk(exp_q.size(), 1'b0);
      program_erase_enable = 1'b0;
      step(4);
      chk(pe_permit, 1'b0);
      program_erase_enable = 1'b1;
      step(4);
      chk(pe_permit, 1'b1);
      // all {cs, oe, od} levels; two driven cases, array then status
      for (int i = 0; i < 16; i++) begin
         arr_rd_data = $urandom;
         status_byte = 8'($urandom);
         rd_sel_status = i[3];
         host.set(i[2:0], 1'b0, a);
         step(5);
         chk(data_bus_oe, ~i[2] & ~i[1] & i[0]);
         chk(standby, i[2]);
         d = rd_sel_status ? {24'h00_0000, status_byte} : arr_rd_data;
         if (data_bus_oe === 1'b1) chk(data_bus_o, d);
      end
      // block decode through the transparent latch; stray burst clock ignored
      bk_run = 1'b1;
      foreach (av[k]) begin
         host.set(3'b011, 1'b0, av[k]);
         step(5);
         chk(arr_addr, av[k]);
         dec = {idx(av[k]), av[k][19:12] == 8'h01, !(av[k] inside {[20'h0_8000:20'h0_FFFF]})};
         chk({blk_index, blk_otp, blk_tuning_protectable}, dec);
         host.set(3'b011, 1'b1, av[k]);
         step(3);
         host.set(3'b011, 1'b1, ~av[k]);
         step(5);
         chk(arr_addr, av[k]);
      end
      bk_run = 1'b0;
      // burst frame: capture with latch low, then one advance step
      burst_cfg_set = 1'b1;
      step(1);
      burst_cfg_set = 1'b0;
      step(2);
      chk(sync_mode, 1'b1);
      a = fhb_addr_t'($urandom);
      host.set(3'b011, 1'b0, a);
      bk_run = 1'b1;
      host.set(3'b011, 1'b1, ~a);
      burst_adv_n = 1'b0;
      for (int i = 0; i < 40 && arr_addr !== a; i++) step(1);
      chk(arr_addr, a);
      for (int i = 0; i < 60 && arr_addr === a; i++) step(1);
      a = a + 20'h0_0001;
      chk(arr_addr, a);
      {bk_run, burst_adv_n} = 2'b01;
      // reset pin low while reading during a program
      host.set(3'b001, 1'b0, a);
      pe_active = 1'b1;
      host.rp(1'b0, 5);
      chk({pe_abort, ctl_reset, data_bus_oe, sync_mode}, 4'b1100);
      pe_active = 1'b0;
      host.rp(1'b1, 1);
      wait_ready();
      exp_q.push_back({~a, d});
      host.wr(~a, d, 1'b1);
      chk(exp_q.size(), 1'b0);
      give_verdict();
   end
endmodule // tb
